// ---- rtl/ascf_consts.svh ----
// Register offsets, field slices, reset values and sizes of the audio serial port
`ifndef ASCF_CONSTS_SVH
`define ASCF_CONSTS_SVH

// Register byte offsets
`define ASCF_OFF_TXDATA 8'h00
`define ASCF_OFF_RXDATA 8'h04
`define ASCF_OFF_STATUS 8'h08
`define ASCF_OFF_IFCFG  8'h0c
`define ASCF_OFF_BCLK   8'h10
`define ASCF_OFF_RXFRM  8'h14

// Reset values
`define ASCF_RST_WORD   32'h0000_0000
`define ASCF_RST_IFCFG  8'h00

// Field slices and widths
`define ASCF_IFCFG_W    8
`define ASCF_DIV_W      16
`define ASCF_FRM_PERIOD 15:0
`define ASCF_FRM_WIDTH  23:16
`define ASCF_FRM_DLY    30:24
`define ASCF_ST_OVR     3

// Legal minimum for dividers and frame periods
`define ASCF_MIN_DIV    16'h0002

// Serial word: bits still to go after the first one
`define ASCF_WORD_LAST  6'h1f

// Transmit buffer shape
`define ASCF_FIFO_W     32
`define ASCF_FIFO_D     8

`endif

// ---- rtl/ascf_pkg.sv ----
// Types shared by the audio serial port files
package ascf_pkg;

  typedef struct packed {
    logic drive;
    logic oe;
  } ascf_pin_t;

  typedef struct packed {
    logic fsx_src;
    logic fsr_src;
    logic clkx_src;
    logic clkr_src;
    logic ena_tx;
    logic ena_rx;
    logic tx_stereo;
    logic mode;
  } ascf_if_cfg_t;

  typedef enum logic {
    ascf_idle  = 1'b0,
    ascf_shift = 1'b1
  } ascf_shift_t;

endpackage

// ---- rtl/ascf_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module ascf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;

  wire push = in_valid & in_ready & clk_en;
  wire pop  = out_valid & out_ready & clk_en;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_idx];

  // Storage needs no reset; only the indices and the count define what is valid
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  // Depth is a power of two so the indices wrap by themselves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= wr_idx + AW'(1);
      end
      if (pop) begin
        rd_idx <= rd_idx + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- rtl/ascf_ctrl.sv ----
// Audio serial port: APB registers, bit clock and frame sync generation, serial data paths
//
// Summary of operation
// R01: Transmit data pin floats while transmit is disabled; when enabled, FIFO words shift out.
// R02: Receive bits are discarded while receive is disabled; when enabled, words are captured.
// R03: Bit clocks and frame syncs run regardless of the datapath enables.
// R04: Stereo transmit sends one word per frame half; mono sends one word per frame.
// R05: Stereo selection applies only in I2S mode; AC97 mode ignores it.
// R06: Mode bit zero selects I2S, one selects AC97 framing.
// R07: Master, slave setups decide which end drives each clock and sync.
// R08: Receive bit clock is master clock divided by bits 31-16; values below 2 invalid.
// R09: Receive divider only matters when the device sources the receive bit clock.
// R10: Transmit bit clock is master clock divided by bits 15-0; values below 2 invalid.
// R11: Even dividers give exact 50% duty; odd dividers give unequal duty.
// R12: Transmit divider only matters when the device sources the transmit bit clock.
// R13: Receive delay field counts bit clocks from frame sync edge to first bit.
// R14: Generated receive frame sync stays active for width bit clocks; width zero gives no pulse.
// R15: Receive frame sync is the bit clock divided by the period field, at least 2.
// R16: Bit clock source one drives the pin from the divider; zero takes the codec's.
// R17: Frame sync source one drives the pin from the generator; zero takes the codec's.
// R18: Odd divider N: high for floor N/2 master cycles, low for the rest.
// R19: Reset zeroes all configuration: datapaths off, I2S mode.
`timescale 1ns/1ns
`include "ascf_consts.svh"
module ascf_ctrl (
  // Clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Codec pins, index 0 transmit, index 1 receive
  input  wire logic [1:0]                  bit_clock_in,
  input  wire logic [1:0]                  frame_sync_in,
  input  wire logic                        rx_serial_in,
  output wire ascf_pkg::ascf_pin_t [1:0]   bit_clock_pin,
  output wire ascf_pkg::ascf_pin_t [1:0]   frame_sync_pin,
  output wire ascf_pkg::ascf_pin_t         tx_serial_pin
);

  ascf_pkg::ascf_if_cfg_t if_cfg;
  logic [31:0]            bclk_cfg;
  logic [31:0]            rxfrm_cfg;

  // Transmit buffer
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [31:0]            fifo_out_data;

  // Per direction timing events
  wire  [1:0]             evt;
  wire  [1:0]             slot_start;

  // Serial engines
  ascf_pkg::ascf_shift_t  tx_state;
  logic [31:0]            tx_shift;
  logic [5:0]             tx_bits;
  logic                   tx_sd;
  logic                   tx_oe;
  ascf_pkg::ascf_shift_t  rx_state;
  logic [31:0]            rx_shift;
  logic [5:0]             rx_bits;
  logic [1:0]             rx_sd_sync;
  logic [31:0]            rx_word;
  logic                   rx_valid;
  logic                   rx_overrun;

  // APB decode
  wire access   = psel & penable;
  wire fire     = access & pready;
  wire sel_tx   = paddr == `ASCF_OFF_TXDATA;
  wire sel_rx   = paddr == `ASCF_OFF_RXDATA;
  wire sel_st   = paddr == `ASCF_OFF_STATUS;
  wire sel_if   = paddr == `ASCF_OFF_IFCFG;
  wire sel_bc   = paddr == `ASCF_OFF_BCLK;
  wire sel_rf   = paddr == `ASCF_OFF_RXFRM;
  wire mapped   = sel_tx | sel_rx | sel_st | sel_if | sel_bc | sel_rf;
  // A full buffer holds the write in its access phase: back-pressure to software
  wire hold     = sel_tx & pwrite & ~fifo_in_ready;
  wire wr_fire  = fire & pwrite & ~pslverr;
  wire rd_take  = fire & ~pwrite & sel_rx;

  wire tx_busy  = tx_state == ascf_pkg::ascf_shift;
  wire rx_busy  = rx_state == ascf_pkg::ascf_shift;
  wire [31:0] status = 32'({rx_busy, tx_busy, rx_overrun, rx_valid, ~fifo_in_ready, ~fifo_out_valid});

  wire [31:0] rd_mux = sel_rx ? rx_word :
                       sel_st ? status :
                       sel_if ? 32'(if_cfg) :
                       sel_bc ? bclk_cfg :
                       sel_rf ? rxfrm_cfg : `ASCF_RST_WORD;

  // Answer one cycle after the access phase opens, later while held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ASCF_RST_WORD;
    end else if (clk_en) begin
      pready  <= access & ~pready & ~hold;
      pslverr <= access & ~pready & ~hold & ~mapped;
      if (access & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_cfg    <= `ASCF_RST_IFCFG;   // see R19
      bclk_cfg  <= `ASCF_RST_WORD;    // see R19
      rxfrm_cfg <= `ASCF_RST_WORD;    // see R19
    end else if (clk_en && wr_fire) begin
      if (sel_if) begin
        if_cfg <= pwdata[`ASCF_IFCFG_W-1:0];
      end
      if (sel_bc) begin
        bclk_cfg <= pwdata;
      end
      if (sel_rf) begin
        rxfrm_cfg <= pwdata;
      end
    end
  end

  ascf_fifo #(
    .WIDTH (`ASCF_FIFO_W),
    .DEPTH (`ASCF_FIFO_D)
  ) u_tx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .in_valid  (wr_fire & sel_tx),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Frame fields are shared by both directions
  wire [15:0] frm_period = rxfrm_cfg[`ASCF_FRM_PERIOD];
  wire [7:0]  frm_width  = rxfrm_cfg[`ASCF_FRM_WIDTH];
  wire [6:0]  frm_dly    = rxfrm_cfg[`ASCF_FRM_DLY];
  wire        period_ok  = frm_period >= `ASCF_MIN_DIV;
  wire        stereo_on  = if_cfg.tx_stereo & ~if_cfg.mode;  // see R04, R05, R06

  for (genvar d = 0; d < 2; d++) begin : g_dir
    wire [15:0] div     = bclk_cfg[d*`ASCF_DIV_W +: `ASCF_DIV_W];  // see R08, R10
    wire        clk_src = d ? if_cfg.clkr_src : if_cfg.clkx_src;
    wire        fs_src  = d ? if_cfg.fsr_src : if_cfg.fsx_src;
    wire        div_ok  = div >= `ASCF_MIN_DIV;

    logic [15:0] div_cnt;
    logic        gen_clk;
    logic [1:0]  clk_sync;
    logic [1:0]  fs_sync;
    logic        clk_prev;
    logic [15:0] frm_cnt;
    logic        gen_fs;
    logic        fs_prev;
    logic [15:0] pos;

    // Divider runs freely so timing settles before data is enabled
    wire [15:0] next_div_cnt = (!div_ok || div_cnt >= div - 16'h0001) ? 16'h0000 :
                               div_cnt + 16'h0001;
    // The codec's clock is used when the device does not source it
    wire act_clk = clk_src ? gen_clk : clk_sync[1];  // see R09, R12, R16
    wire rise    = act_clk & ~clk_prev;
    wire fall    = ~act_clk & clk_prev;
    wire [15:0] next_frm_cnt = (!period_ok || frm_cnt >= frm_period - 16'h0001) ? 16'h0000 :
                               frm_cnt + 16'h0001;
    wire act_fs  = fs_src ? gen_fs : fs_sync[1];  // see R17
    // Transmit changes on the falling edge, receive samples on the rising edge
    wire ev      = d ? rise : fall;
    wire fs_edge = act_fs & ~fs_prev;
    wire [15:0] next_pos = fs_edge ? 16'h0000 : pos + 16'(pos != 16'hffff);
    wire first   = next_pos == 16'(frm_dly);  // see R13
    wire second  = (d == 0) && stereo_on && next_pos == 16'(frm_dly) + (frm_period >> 1);

    assign evt[d]        = ev;
    assign slot_start[d] = ev & (first | second);  // see R04
    assign bit_clock_pin[d]  = '{drive: gen_clk, oe: clk_src};  // see R16, R07
    assign frame_sync_pin[d] = '{drive: gen_fs, oe: fs_src};    // see R17, R07

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_cnt  <= 16'h0000;
        gen_clk  <= 1'b0;
        clk_sync <= 2'h0;
        fs_sync  <= 2'h0;
        clk_prev <= 1'b0;
      end else if (clk_en) begin
        div_cnt  <= next_div_cnt;
        // High for floor(N/2) of N cycles: exact half for even N
        gen_clk  <= div_ok && next_div_cnt < (div >> 1);  // see R03, R11, R18
        clk_sync <= {clk_sync[0], bit_clock_in[d]};
        fs_sync  <= {fs_sync[0], frame_sync_in[d]};
        clk_prev <= act_clk;
      end
    end

    // Frame sync counts bit clock periods; width zero gives no pulse
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        frm_cnt <= 16'h0000;
        gen_fs  <= 1'b0;
        fs_prev <= 1'b0;
        pos     <= 16'h0000;
      end else if (clk_en) begin
        if (fall) begin
          frm_cnt <= next_frm_cnt;                                // see R15
          gen_fs  <= period_ok && next_frm_cnt < 16'(frm_width);  // see R03, R14
        end
        if (ev) begin
          fs_prev <= act_fs;
          pos     <= next_pos;
        end
      end
    end
  end

  // Transmit: pop one word per slot; an empty buffer sends zeros
  wire        tx_load  = evt[0] & slot_start[0] & if_cfg.ena_tx;
  wire [31:0] tx_word  = fifo_out_valid ? fifo_out_data : `ASCF_RST_WORD;
  assign fifo_out_ready = tx_load;  // see R01
  assign tx_serial_pin  = '{drive: tx_sd, oe: tx_oe};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= ascf_pkg::ascf_idle;
      tx_shift <= `ASCF_RST_WORD;
      tx_bits  <= 6'h00;
      tx_sd    <= 1'b0;
      tx_oe    <= 1'b0;
    end else if (clk_en) begin
      tx_oe <= if_cfg.ena_tx;  // see R01
      if (!if_cfg.ena_tx) begin
        tx_state <= ascf_pkg::ascf_idle;
        tx_sd    <= 1'b0;
      end else if (tx_load) begin
        tx_state <= ascf_pkg::ascf_shift;
        tx_sd    <= tx_word[31];
        tx_shift <= {tx_word[30:0], 1'b0};
        tx_bits  <= `ASCF_WORD_LAST;
      end else if (evt[0]) begin
        unique case (tx_state)
          ascf_pkg::ascf_idle: begin
            tx_sd <= 1'b0;
          end
          ascf_pkg::ascf_shift: begin
            if (tx_bits == 6'h00) begin
              tx_state <= ascf_pkg::ascf_idle;
              tx_sd    <= 1'b0;
            end else begin
              tx_sd    <= tx_shift[31];
              tx_shift <= {tx_shift[30:0], 1'b0};
              tx_bits  <= tx_bits - 6'h01;
            end
          end
        endcase
      end
    end
  end

  // Receive: the data pin is synchronised like the clocks
  wire rx_bit  = rx_sd_sync[1];
  wire rx_load = evt[1] & slot_start[1] & if_cfg.ena_rx;
  wire rx_done = evt[1] & ~slot_start[1] & if_cfg.ena_rx & rx_busy & (rx_bits == 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sd_sync <= 2'h0;
      rx_state   <= ascf_pkg::ascf_idle;
      rx_shift   <= `ASCF_RST_WORD;
      rx_bits    <= 6'h00;
      rx_word    <= `ASCF_RST_WORD;
    end else if (clk_en) begin
      rx_sd_sync <= {rx_sd_sync[0], rx_serial_in};
      if (!if_cfg.ena_rx) begin
        rx_state <= ascf_pkg::ascf_idle;  // see R02
      end else if (rx_load) begin
        rx_state <= ascf_pkg::ascf_shift;
        rx_shift <= {31'h0000_0000, rx_bit};
        rx_bits  <= `ASCF_WORD_LAST;
      end else if (evt[1]) begin
        unique case (rx_state)
          ascf_pkg::ascf_idle: begin
            rx_bits <= 6'h00;
          end
          ascf_pkg::ascf_shift: begin
            rx_shift <= {rx_shift[30:0], rx_bit};
            rx_bits  <= rx_bits - 6'h01;
            if (rx_done) begin
              rx_state <= ascf_pkg::ascf_idle;
              rx_word  <= {rx_shift[30:0], rx_bit};  // see R02
            end
          end
        endcase
      end
    end
  end

  // A new word wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid   <= 1'b0;
      rx_overrun <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= rx_done | (rx_valid & ~rd_take);
      rx_overrun <= (rx_done & rx_valid & ~rd_take) |
                    (rx_overrun & ~(wr_fire & sel_st & pwdata[`ASCF_ST_OVR]));
    end
  end
endmodule

// ---- bench/ascf_ctrl_checker.sv ----
// Port checker for the audio serial port control block
`timescale 1ns/1ns
module ascf_ctrl_checker (
  // Clock, reset, bus
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Codec pins
  input wire ascf_pkg::ascf_pin_t [1:0] bit_clock_pin,
  input wire ascf_pkg::ascf_pin_t [1:0] frame_sync_pin,
  input wire ascf_pkg::ascf_pin_t       tx_serial_pin
);
  logic        wr;
  logic        ck;
  logic [7:0]  cfg;
  logic [31:0] div;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [5:0]  age;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign ck = bit_clock_pin[0].drive;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 8'h00;
      div <= 32'h0000_0000;
    end else if (wr && paddr == 8'h0c) begin
      cfg <= pwdata[7:0];
    end else if (wr && paddr == 8'h10) begin
      div <= pwdata;
    end
  end
  // Age lets a new divider settle before its period is judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 6'h00;
      hi  <= 16'h0000;
      lo  <= 16'h0000;
    end else begin
      age <= (wr && paddr == 8'h10) ? 6'h00 : age + 6'(age != 6'h3f);
      hi  <= ck ? hi + 16'h0001 : 16'h0000;
      lo  <= ck ? 16'h0000 : lo + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_idle: assert property (!$past(presetn) |-> !tx_serial_pin.oe && bit_clock_pin == '0 && frame_sync_pin == '0)
    else $error("pins active after reset");
  a_tx_float: assert property (!cfg[3] && !$past(cfg[3]) |-> !tx_serial_pin.oe)
    else $error("transmit pin driven while disabled");
  a_clk_oe: assert property (bit_clock_pin[0].oe == cfg[5] && bit_clock_pin[1].oe == cfg[4])
    else $error("bit clock driver disagrees with source");
  a_sync_oe: assert property (frame_sync_pin[0].oe == cfg[7] && frame_sync_pin[1].oe == cfg[6])
    else $error("frame sync driver disagrees with source");
  a_tx_div_low: assert property (cfg[5] && age > 40 && div[15:0] < 2 |-> !bit_clock_pin[0].drive)
    else $error("transmit clock runs with illegal divider");
  a_rx_div_low: assert property (cfg[4] && age > 40 && div[31:16] < 2 |-> !bit_clock_pin[1].drive)
    else $error("receive clock runs with illegal divider");
  a_high_len: assert property (cfg[5] && age > 40 && $fell(ck) |-> hi == div[15:0] >> 1)
    else $error("transmit clock high time wrong");
  a_low_len: assert property (cfg[5] && age > 40 && $rose(ck) |-> lo == div[15:0] - (div[15:0] >> 1))
    else $error("transmit clock low time wrong");
endmodule

bind ascf_ctrl ascf_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .bit_clock_pin(bit_clock_pin), .frame_sync_pin(frame_sync_pin), .tx_serial_pin(tx_serial_pin));

// ---- bench/ascf_codec_model.sv ----
// Behavioural codec on the serial pins
`timescale 1ns/1ns
module ascf_codec_model #(
  parameter int DLY  = 1,
  parameter int HALF = 40
) (
  // Clock
  input  wire logic                      pclk,
  // Device pins
  input  wire ascf_pkg::ascf_pin_t [1:0] bit_clock_pin,
  input  wire ascf_pkg::ascf_pin_t [1:0] frame_sync_pin,
  input  wire ascf_pkg::ascf_pin_t       tx_serial_pin,
  // Codec side
  input  wire logic [31:0]               rx_word,
  output wire logic [1:0]                bit_clock_in,
  output wire logic [1:0]                frame_sync_in,
  output      logic                      rx_serial_in
);
  logic [31:0] txq[$];
  logic [31:0] sh;
  logic [1:0]  ck_q = 2'b00;
  logic [1:0]  fs_q = 2'b00;
  logic        live = 1'b0;
  int          tix;
  int          rix;
  int          j;
  // Device sources the clock and sync of the direction each test uses, so the codec keeps still
  assign bit_clock_in  = 2'b00;
  assign frame_sync_in = 2'b00;
  initial rx_serial_in = 1'b0;
  always @(posedge pclk) begin
    ck_q <= {bit_clock_pin[1].drive, bit_clock_pin[0].drive};
    if (bit_clock_pin[0].drive && !ck_q[0]) begin
      tix = (frame_sync_pin[0].drive && !fs_q[0]) ? 0 : tix + 1;
      fs_q[0] <= frame_sync_pin[0].drive;
      j = tix - 1 - DLY;
      if (j >= HALF) j = j - HALF;
      if (j >= 0 && j < 32) begin
        sh = {sh[30:0], tx_serial_pin.drive};
        if (j == 0) live = tx_serial_pin.oe;
        if (j == 31 && live) txq.push_back(sh);
      end
    end
    if (bit_clock_pin[1].drive && !ck_q[1]) begin
      rix = (frame_sync_pin[1].drive && !fs_q[1]) ? 0 : rix + 1;
      fs_q[1] <= frame_sync_pin[1].drive;
    end
    // Outside the slot the line toggles so stale data is never read as valid
    if (!bit_clock_pin[1].drive && ck_q[1]) begin
      // The bit set here is taken at the next rise, one position on
      j = rix + 1 - DLY;
      rx_serial_in <= (j >= 0 && j < 32) ? rx_word[31 - j] : !rx_serial_in;
    end
  end
endmodule

// ---- bench/ascf_ctrl_tb.sv ----
// Testbench for the audio serial port control block
`timescale 1ns/1ns
module ascf_ctrl_tb;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [7:0]                paddr = 8'h00;
  logic [31:0]               pwdata = 32'h0000_0000;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [1:0]                bck_in;
  logic [1:0]                fs_in;
  logic                      rx_in;
  logic [31:0]               rxw = 32'h5a3c_96e1;
  logic [31:0]               rdat;
  logic                      err;
  logic                      msel = 1'b0;
  logic                      probe;
  ascf_pkg::ascf_pin_t [1:0] bcp;
  ascf_pkg::ascf_pin_t [1:0] fsp;
  ascf_pkg::ascf_pin_t       txp;
  int                        failures = 0;
  int                        n_tests = 0;
  int                        cyc;
  int                        h;
  int                        l;
  always #5 pclk = ~pclk;
  assign probe = msel ? fsp[1].drive : bcp[0].drive;
  ascf_ctrl dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_in(bck_in), .frame_sync_in(fs_in), .rx_serial_in(rx_in), .bit_clock_pin(bcp),
    .frame_sync_pin(fsp), .tx_serial_pin(txp));
  ascf_codec_model model_u (.pclk(pclk), .bit_clock_pin(bcp), .frame_sync_pin(fsp), .tx_serial_pin(txp),
    .rx_word(rxw), .bit_clock_in(bck_in), .frame_sync_in(fs_in), .rx_serial_in(rx_in));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A wait that ran out of its bound ends the run as a mismatch
  task automatic expire(input logic ok);
    if (!ok) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (pready !== 1'b1 && cyc < 1000);
    expire(pready === 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Sampled on falling edges, clear of the design's updates
  task automatic measure();
    h = 0;
    l = 0;
    for (int i = 0; i < 300 && probe !== 1'b0; i++) @(negedge pclk);
    for (int i = 0; i < 300 && probe !== 1'b1; i++) @(negedge pclk);
    while (probe === 1'b1 && h < 300) begin
      h++;
      @(negedge pclk);
    end
    while (probe === 1'b0 && l < 300) begin
      l++;
      @(negedge pclk);
    end
    @(posedge pclk);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'h0c + 8'(4 * i), 32'h0);
      chk("reset value", rdat, 32'h0);
    end
    apb(1'b1, 8'h10, 32'h1234_abcd);
    apb(1'b1, 8'h14, 32'h7f5a_0c3b);
    apb(1'b1, 8'h0c, 32'hffff_ff01);
    apb(1'b0, 8'h10, 32'h0);
    chk("bit clock reg", rdat, 32'h1234_abcd);
    apb(1'b0, 8'h14, 32'h0);
    chk("rx frame reg", rdat, 32'h7f5a_0c3b);
    apb(1'b0, 8'h0c, 32'h0);
    chk("interface reg", rdat, 32'h0000_0001);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", err, 1'b1);
  endtask
  task automatic t_div();
    apb(1'b1, 8'h0c, 32'h0000_0020);
    msel = 1'b0;
    for (int n = 1; n < 6; n++) begin
      apb(1'b1, 8'h10, 32'(n));
      repeat (60) @(posedge pclk);
      measure();
      chk("clock high", h, n < 2 ? 0 : n / 2);
      chk("clock period", h + l, n < 2 ? 300 : n);
    end
  endtask
  task automatic t_sync();
    apb(1'b1, 8'h0c, 32'h0000_0050);
    apb(1'b1, 8'h10, 32'h0002_0000);
    apb(1'b1, 8'h14, 32'h0002_0005);
    msel = 1'b1;
    repeat (60) @(posedge pclk);
    measure();
    chk("sync high", h, 4);
    chk("sync period", h + l, 10);
  endtask
  task automatic t_tx(input logic m, input logic s);
    logic [31:0] c;
    int          k;
    c = {24'h0, 6'h28, s, m};
    apb(1'b1, 8'h0c, c);
    apb(1'b1, 8'h10, 32'h0008_0002);
    apb(1'b1, 8'h14, 32'h0101_0050);
    for (int i = 1; i < 9; i++) apb(1'b1, 8'h00, 32'hc0de_0000 + i);
    apb(1'b0, 8'h08, 32'h0);
    chk("fifo full", rdat[1:0], 2'b10);
    model_u.txq.delete();
    apb(1'b1, 8'h0c, c | 32'h08);
    apb(1'b1, 8'h00, 32'hc0de_0009);
    chk("full stall", 32'(cyc > 2), 1);
    k = (s && !m) ? 9 : 17;
    for (int i = 0; i < 4000 && model_u.txq.size() < k + 2; i++) @(posedge pclk);
    expire(model_u.txq.size() >= k + 2);
    while (model_u.txq.size() > 0 && model_u.txq[0] === 32'h0) void'(model_u.txq.pop_front());
    for (int i = 0; i < k; i++) begin
      chk("tx word", model_u.txq[i], k == 9 ? 32'hc0de_0001 + i : (i % 2 ? 0 : 32'hc0de_0001 + i / 2));
    end
    apb(1'b0, 8'h08, 32'h0);
    chk("fifo empty", rdat[0], 1'b1);
    apb(1'b1, 8'h0c, c);
  endtask
  task automatic t_rx();
    apb(1'b1, 8'h0c, 32'h0000_0050);
    apb(1'b1, 8'h10, 32'h0008_0002);
    apb(1'b1, 8'h14, 32'h0101_0050);
    repeat (1400) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk("rx idle", rdat[2], 1'b0);
    apb(1'b1, 8'h0c, 32'h0000_0054);
    for (int i = 0; i < 600 && rdat[2] !== 1'b1; i++) apb(1'b0, 8'h08, 32'h0);
    expire(rdat[2] === 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("rx word", rdat, rxw);
    apb(1'b0, 8'h08, 32'h0);
    chk("rx taken", rdat[2], 1'b0);
    for (int i = 0; i < 600 && rdat[3] !== 1'b1; i++) apb(1'b0, 8'h08, 32'h0);
    expire(rdat[3] === 1'b1);
    chk("overrun", rdat[3], 1'b1);
    apb(1'b1, 8'h08, 32'h0000_0008);
    apb(1'b0, 8'h08, 32'h0);
    chk("overrun clear", rdat[3], 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_div();
    t_sync();
    for (int i = 0; i < 4; i++) t_tx(i[0], i[1]);
    t_rx();
    give_verdict();
  end
endmodule
